// [pkg/pdsrb_pkg.sv]
package pdsrb_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [5:0] ADDR_RESERVED_ZERO = 6'h00;
  localparam logic [5:0] ADDR_UNLOCK_KEY = 6'h01;
  localparam logic [5:0] ADDR_FAULT_CONFIG = 6'h02;
  localparam logic [5:0] ADDR_RESERVED_THREE = 6'h03;
  localparam logic [5:0] ADDR_FAULT_PIN_ENABLE_LOW = 6'h04;
  localparam logic [5:0] ADDR_FAULT_PIN_ENABLE_HIGH = 6'h05;
  localparam logic [5:0] ADDR_SHUTDOWN_ENABLE_LOW = 6'h06;
  localparam logic [5:0] ADDR_SHUTDOWN_ENABLE_HIGH = 6'h07;
  localparam logic [5:0] ADDR_FAULT_FLAGS_LOW = 6'h08;
  localparam logic [5:0] ADDR_FAULT_FLAGS_HIGH = 6'h09;
  localparam logic [5:0] ADDR_CURRENT_SENSE_CONFIG = 6'h0a;
  localparam logic [5:0] ADDR_GATE_DRIVE_CONFIG = 6'h0b;
  localparam logic [5:0] ADDR_RESET_CAUSE = 6'h0c;
  localparam logic [5:0] ADDR_SPARE_AND_HYSTERESIS = 6'h0d;

  // ************************************************************
  // Reset values and field layout
  // ************************************************************
  localparam logic [3:0] RST_UNLOCK_KEY = 4'h0;
  localparam logic [7:0] RST_FAULT_CONFIG = 8'h00;
  localparam logic [7:0] RST_ENABLE_LOW = 8'hff;
  localparam logic RST_ENABLE_THERMAL = 1'b1;
  localparam logic [7:0] RST_FLAGS_LOW = 8'h00;
  localparam logic [2:0] RST_SENSE_OFFSET = 3'h0;
  localparam logic [1:0] RST_DEAD_TIME = 2'h0;
  localparam logic [2:0] RST_RESET_CAUSE = 3'h0;
  localparam logic [1:0] RST_HYSTERESIS = 2'h0;
  localparam logic [7:0] FAULT_CONFIG_MASK = 8'hf7;
  localparam int FLAG_HOLD_BIT = 7;
  localparam int MOTOR_TH_LSB = 4;
  localparam int REG_UV_TH_BIT = 2;
  localparam int BATT_UV_TH_LSB = 0;
  localparam logic [2:0] MOTOR_TH_MAX = 3'h4;
  localparam logic [2:0] SENSE_OFFSET_MAX = 3'h4;
  localparam logic [2:0] CODE_DEFAULT = 3'h0;

  // ************************************************************
  // Serial frame
  // ************************************************************
  localparam logic [1:0] ACCESS_READ = 2'h0;
  localparam logic [1:0] ACCESS_WRITE = 2'h1;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] HEADER_BITS = 5'h08;
  localparam logic [4:0] COUNT_MAX = 5'h1f;
  localparam logic [3:0] KEY_FIRST = 4'h5;
  localparam logic [3:0] KEY_SECOND = 4'h8;
  localparam logic [3:0] KEY_THIRD = 4'h7;
  localparam logic [3:0] KEY_LOCK = 4'h0;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_GOT_FIRST = 2'b01,
    KEY_GOT_SECOND = 2'b11,
    KEY_OPEN = 2'b10
  } pdsrb_key_type;

  typedef struct packed {
    logic [1:0] access;
    logic [5:0] addr;
    logic [7:0] data;
  } pdsrb_frame_type;

  typedef struct packed {
    logic motor_overcurrent_flag;
    logic regulator_overcurrent_flag;
    logic regulator_overvolt_flag;
    logic core_supply_overvolt_flag;
    logic pump_overvolt_flag;
    logic pump_undervolt_flag;
    logic battery_overvolt_flag;
    logic battery_undervolt_flag;
  } pdsrb_faults_type;

  typedef struct packed {
    logic flag_hold_enable;
    logic [2:0] motor_overcurrent_threshold;
    logic regulator_undervolt_threshold;
    logic [1:0] battery_undervolt_threshold;
    logic [2:0] sense_offset_select;
    logic [1:0] dead_time_select;
    logic [1:0] comparator_hysteresis_select;
  } pdsrb_config_type;

endpackage : pdsrb_pkg

// [design/pdsrb_register_bank.sv]
`timescale 1ns/100ps
// Behaviour
// - Reserved bits and addresses read zero, ignore writes
// - Locked after reset; protected writes ignored
// - Keys 0x5, 0x8, 0x7 in a row unlock
// - Writing 0x0 to unlock relocks bank
// - Hold bit chooses live or sticky flags
// - Held flags clear on write one only
// - Motor threshold codes above four mean 2 V
// - Bit 2 picks regulator undervoltage threshold
// - Bits 1:0 pick battery undervoltage threshold
// - Enabled low flags pull fault output low
// - Thermal flag enable for fault output
// - Enabled low flags turn gate drive off
// - Thermal flag enable for gate shutdown
// - Low flag register bit order fixed
// - Thermal flag in high register bit 0
// - Sense offset codes above four mean 0.5 V
// - Two-bit dead time selection
// - Reset cause cleared by any read of its own address
// - Two-bit comparator hysteresis selection
// - Spare bits ignore writes, read zero
// - Input frame: access, address, data
// - Output frame: error, marker, read data
// - Only sixteen-pulse frames may write
// - Sample rising, launch falling, MSB first
// - Serial output released while select high
module pdsrb_register_bank
  import pdsrb_pkg::*;
(
  // Core clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Serial link
  input wire logic sck_in,
  input wire logic cs_b_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_b_out,
  // Detector levels
  input wire pdsrb_faults_type fault_live_in,
  input wire logic thermal_live_in,
  input wire logic undervolt_reset_cause_in,
  input wire logic watchdog_reset_cause_in,
  input wire logic clock_monitor_reset_cause_in,
  // Controls to the analog side
  output logic fault_b_out,
  output logic gate_off_out,
  output pdsrb_config_type config_out
);

  // ************************************************************
  // Core state
  // ************************************************************
  typedef struct packed {
    logic [2:0] cs_sync;
    logic [2:0] tog_sync;
    logic [8:0] live_s1;
    logic [8:0] live_s2;
    logic [2:0] cause_s1;
    logic [2:0] cause_s2;
    logic [4:0] pulse_cnt;
    pdsrb_key_type key;
    logic [3:0] unlock_key;
    logic [7:0] fault_config;
    logic [7:0] pin_en_low;
    logic pin_en_thermal;
    logic [7:0] sd_en_low;
    logic sd_en_thermal;
    logic [7:0] flags_low;
    logic flag_thermal;
    logic [2:0] sense_offset;
    logic [1:0] dead_time;
    logic [2:0] reset_cause;
    logic [1:0] hysteresis;
    logic frame_fault;
    logic [7:0] rd_byte;
    logic fault_b;
    logic gate_off;
  } pdsrb_core_type;

  localparam pdsrb_core_type CORE_RESET = '{
    cs_sync: 3'h7, tog_sync: 3'h0, live_s1: 9'h000, live_s2: 9'h000,
    cause_s1: 3'h0, cause_s2: 3'h0, pulse_cnt: 5'h00, key: KEY_IDLE,
    unlock_key: RST_UNLOCK_KEY, fault_config: RST_FAULT_CONFIG,
    pin_en_low: RST_ENABLE_LOW, pin_en_thermal: RST_ENABLE_THERMAL,
    sd_en_low: RST_ENABLE_LOW, sd_en_thermal: RST_ENABLE_THERMAL,
    flags_low: RST_FLAGS_LOW, flag_thermal: 1'b0,
    sense_offset: RST_SENSE_OFFSET, dead_time: RST_DEAD_TIME,
    reset_cause: RST_RESET_CAUSE, hysteresis: RST_HYSTERESIS,
    frame_fault: 1'b0, rd_byte: 8'h00, fault_b: 1'b1, gate_off: 1'b0
  };

  // ************************************************************
  // Link state
  // ************************************************************
  typedef struct packed {
    logic [15:0] rx_word;
    logic rx_toggle;
  } pdsrb_rx_type;

  typedef struct packed {
    logic first;
    logic [4:0] cnt;
  } pdsrb_pos_type;

  pdsrb_core_type state;
  pdsrb_core_type next_state;
  pdsrb_rx_type rx;
  pdsrb_rx_type next_rx;
  pdsrb_pos_type pos;
  pdsrb_pos_type next_pos;
  logic [4:0] tx_idx;
  logic frame_rst_b;
  pdsrb_frame_type frame;
  logic [15:0] tx_word;

  // ************************************************************
  // Register read mux
  // ************************************************************
  function automatic logic [7:0] read_reg(input pdsrb_core_type s, input logic [5:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      ADDR_UNLOCK_KEY: v = {4'h0, s.unlock_key};
      ADDR_FAULT_CONFIG: v = s.fault_config;
      ADDR_FAULT_PIN_ENABLE_LOW: v = s.pin_en_low;
      ADDR_FAULT_PIN_ENABLE_HIGH: v = {7'h00, s.pin_en_thermal};
      ADDR_SHUTDOWN_ENABLE_LOW: v = s.sd_en_low;
      ADDR_SHUTDOWN_ENABLE_HIGH: v = {7'h00, s.sd_en_thermal};
      ADDR_FAULT_FLAGS_LOW: v = s.flags_low;
      ADDR_FAULT_FLAGS_HIGH: v = {7'h00, s.flag_thermal};
      ADDR_CURRENT_SENSE_CONFIG: v = {5'h00, s.sense_offset};
      ADDR_GATE_DRIVE_CONFIG: v = {6'h00, s.dead_time};
      ADDR_RESET_CAUSE: v = {5'h00, s.reset_cause};
      ADDR_SPARE_AND_HYSTERESIS: v = {6'h00, s.hysteresis};
      default: v = 8'h00;
    endcase
    return v;
  endfunction : read_reg

  // ************************************************************
  // Link side, serial clock domain
  // ************************************************************
  // Select high ends the frame without needing a further clock edge
  assign frame_rst_b = rst_b_in & ~cs_b_in;

  always_comb begin
    next_rx = rx;
    next_rx.rx_word = {rx.rx_word[14:0], sdi_in};
    next_rx.rx_toggle = ~rx.rx_toggle;
  end

  always_ff @(posedge sck_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx <= '0;
    end else begin
      rx <= next_rx;
    end
  end

  always_comb begin
    next_pos = pos;
    next_pos.first = 1'b0;
    if (pos.first) begin
      next_pos.cnt = 5'h01;
    end else if (pos.cnt != COUNT_MAX) begin
      next_pos.cnt = pos.cnt + 5'h01;
    end
  end

  always_ff @(posedge sck_in or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      pos <= '{first: 1'b1, cnt: 5'h00};
    end else begin
      pos <= next_pos;
    end
  end

  // New bit goes out on the falling edge after each sample
  always_ff @(negedge sck_in or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      tx_idx <= 5'h00;
    end else begin
      tx_idx <= pos.first ? 5'h00 : pos.cnt;
    end
  end

  // Fault and read byte stay still while the link reads them
  assign tx_word = {1'b0, state.frame_fault, 5'h00, 1'b1, state.rd_byte};
  assign sdo_out = (tx_idx < FRAME_BITS) ? tx_word[4'hf - tx_idx[3:0]] : 1'b0;
  assign sdo_oe_b_out = cs_b_in;

  // ************************************************************
  // Core side
  // ************************************************************
  // Words are sampled only after select or the pulse toggle settle
  assign frame = pdsrb_frame_type'(rx.rx_word);

  always_comb begin
    logic pulse;
    logic frame_end;
    logic frame_start;
    logic do_write;
    logic hold;
    logic [7:0] clr_low;
    logic clr_thermal;
    logic [2:0] cause_clr;
    pulse = 1'b0;
    frame_end = 1'b0;
    frame_start = 1'b0;
    do_write = 1'b0;
    hold = state.fault_config[FLAG_HOLD_BIT];
    clr_low = 8'h00;
    clr_thermal = 1'b0;
    cause_clr = 3'h0;
    next_state = state;
    next_state.cs_sync = {state.cs_sync[1:0], cs_b_in};
    next_state.tog_sync = {state.tog_sync[1:0], rx.rx_toggle};
    next_state.live_s1 = {fault_live_in, thermal_live_in};
    next_state.live_s2 = state.live_s1;
    next_state.cause_s1 = {undervolt_reset_cause_in, watchdog_reset_cause_in,
                           clock_monitor_reset_cause_in};
    next_state.cause_s2 = state.cause_s1;
    pulse = state.tog_sync[2] ^ state.tog_sync[1];
    frame_start = state.cs_sync[2] & ~state.cs_sync[1];
    frame_end = ~state.cs_sync[2] & state.cs_sync[1];
    if (frame_start) begin
      next_state.pulse_cnt = 5'h00;
    end else if (pulse && !state.cs_sync[1] && state.pulse_cnt != COUNT_MAX) begin
      next_state.pulse_cnt = state.pulse_cnt + 5'h01;
      if (state.pulse_cnt + 5'h01 == HEADER_BITS) begin
        next_state.rd_byte = read_reg(state, rx.rx_word[5:0]);
        if (rx.rx_word[7:6] == ACCESS_READ && rx.rx_word[5:0] == ADDR_RESET_CAUSE) begin
          cause_clr = 3'h7;
        end
      end
    end
    if (frame_end) begin
      next_state.frame_fault = (state.pulse_cnt != FRAME_BITS) ||
        (frame.access != ACCESS_READ && frame.access != ACCESS_WRITE);
      do_write = (state.pulse_cnt == FRAME_BITS) && (frame.access == ACCESS_WRITE);
    end
    if (do_write) begin
      unique case (frame.addr)
        ADDR_UNLOCK_KEY: begin
          next_state.unlock_key = frame.data[3:0];
          if (frame.data[3:0] == KEY_LOCK) begin
            next_state.key = KEY_IDLE;
          end else begin
            unique case (state.key)
              KEY_IDLE: next_state.key = (frame.data[3:0] == KEY_FIRST) ?
                KEY_GOT_FIRST : KEY_IDLE;
              KEY_GOT_FIRST: next_state.key = (frame.data[3:0] == KEY_SECOND) ?
                KEY_GOT_SECOND : ((frame.data[3:0] == KEY_FIRST) ? KEY_GOT_FIRST : KEY_IDLE);
              KEY_GOT_SECOND: next_state.key = (frame.data[3:0] == KEY_THIRD) ?
                KEY_OPEN : ((frame.data[3:0] == KEY_FIRST) ? KEY_GOT_FIRST : KEY_IDLE);
              KEY_OPEN: next_state.key = KEY_OPEN;
            endcase
          end
        end
        ADDR_FAULT_CONFIG: begin
          if (state.key == KEY_OPEN) begin
            next_state.fault_config = frame.data & FAULT_CONFIG_MASK;
          end
        end
        ADDR_FAULT_PIN_ENABLE_LOW: begin
          if (state.key == KEY_OPEN) begin
            next_state.pin_en_low = frame.data;
          end
        end
        ADDR_FAULT_PIN_ENABLE_HIGH: begin
          if (state.key == KEY_OPEN) begin
            next_state.pin_en_thermal = frame.data[0];
          end
        end
        ADDR_SHUTDOWN_ENABLE_LOW: begin
          if (state.key == KEY_OPEN) begin
            next_state.sd_en_low = frame.data;
          end
        end
        ADDR_SHUTDOWN_ENABLE_HIGH: begin
          if (state.key == KEY_OPEN) begin
            next_state.sd_en_thermal = frame.data[0];
          end
        end
        ADDR_FAULT_FLAGS_LOW: begin
          clr_low = hold ? frame.data : 8'h00;
        end
        ADDR_FAULT_FLAGS_HIGH: begin
          clr_thermal = hold & frame.data[0];
        end
        ADDR_CURRENT_SENSE_CONFIG: begin
          if (state.key == KEY_OPEN) begin
            next_state.sense_offset = frame.data[2:0];
          end
        end
        ADDR_GATE_DRIVE_CONFIG: begin
          if (state.key == KEY_OPEN) begin
            next_state.dead_time = frame.data[1:0];
          end
        end
        ADDR_SPARE_AND_HYSTERESIS: begin
          next_state.hysteresis = frame.data[1:0];
        end
        default: begin
          next_state.unlock_key = state.unlock_key;
        end
      endcase
    end
    // Clear first, then set, so an event in the clearing cycle survives
    if (hold) begin
      next_state.flags_low = (state.flags_low & ~clr_low) | state.live_s2[8:1];
      next_state.flag_thermal = (state.flag_thermal & ~clr_thermal) | state.live_s2[0];
    end else begin
      next_state.flags_low = state.live_s2[8:1];
      next_state.flag_thermal = state.live_s2[0];
    end
    next_state.reset_cause = (state.reset_cause & ~cause_clr) | state.cause_s2;
    next_state.fault_b = ~(|(next_state.flags_low & state.pin_en_low) |
      (next_state.flag_thermal & state.pin_en_thermal));
    next_state.gate_off = |(next_state.flags_low & state.sd_en_low) |
      (next_state.flag_thermal & state.sd_en_thermal);
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= CORE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign fault_b_out = state.fault_b;
  assign gate_off_out = state.gate_off;

  always_comb begin
    config_out.flag_hold_enable = state.fault_config[FLAG_HOLD_BIT];
    config_out.motor_overcurrent_threshold =
      (state.fault_config[MOTOR_TH_LSB +: 3] > MOTOR_TH_MAX) ?
      CODE_DEFAULT : state.fault_config[MOTOR_TH_LSB +: 3];
    config_out.regulator_undervolt_threshold = state.fault_config[REG_UV_TH_BIT];
    config_out.battery_undervolt_threshold = state.fault_config[BATT_UV_TH_LSB +: 2];
    config_out.sense_offset_select = (state.sense_offset > SENSE_OFFSET_MAX) ?
      CODE_DEFAULT : state.sense_offset;
    config_out.dead_time_select = state.dead_time;
    config_out.comparator_hysteresis_select = state.hysteresis;
  end

endmodule : pdsrb_register_bank

// [tb/pdsrb_register_bank_assertions.sv]
`timescale 1ns/100ps
module pdsrb_register_bank_assertions
  import pdsrb_pkg::*;
(
  // Core clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Serial link
  input wire logic sck_in,
  input wire logic cs_b_in,
  input wire logic sdo_out,
  input wire logic sdo_oe_b_out,
  // Detectors and controls
  input wire pdsrb_faults_type fault_live_in,
  input wire logic thermal_live_in,
  input wire logic fault_b_out,
  input wire logic gate_off_out,
  input wire pdsrb_config_type config_out
);
  logic cs_q;
  logic [5:0] since_cs;
  logic quiet;
  assign quiet = (fault_live_in == 8'h00) && !thermal_live_in && !config_out.flag_hold_enable;
  // Cycles since a frame ended; register writes may only land close to it
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cs_q <= 1'b1;
      since_cs <= 6'h3f;
    end else begin
      cs_q <= cs_b_in;
      if (cs_b_in && !cs_q) begin
        since_cs <= 6'h00;
      end else if (since_cs != 6'h3f) begin
        since_cs <= since_cs + 6'h01;
      end
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // ****
  // Checks
  // ****
  AST_SDO_RELEASE: assert property (sdo_oe_b_out == cs_b_in)
    else $error("sdo enable differs from select");
  AST_MOTOR_CODE: assert property (config_out.motor_overcurrent_threshold <= MOTOR_TH_MAX)
    else $error("motor threshold code out of range");
  AST_SENSE_CODE: assert property (config_out.sense_offset_select <= SENSE_OFFSET_MAX)
    else $error("sense offset code out of range");
  AST_CFG_NEAR_FRAME: assert property ($changed(config_out) |-> since_cs < 6'd12)
    else $error("config changed away from a frame end");
  AST_FAULT_QUIET: assert property (quiet [*8] |-> fault_b_out)
    else $error("fault output low with no fault");
  AST_GATE_QUIET: assert property (quiet [*8] |-> !gate_off_out)
    else $error("gate off with no fault");
  AST_SDO_HOLD: assert property ((!cs_b_in && !$past(cs_b_in) && sck_in && $past(sck_in))
    |-> $stable(sdo_out)) else $error("sdo moved while clock high");
  AST_FIRST_BIT: assert property ($fell(cs_b_in) |=> !sdo_out)
    else $error("first output bit not zero");
  AST_RESET_LEVELS: assert property ($rose(rst_b_in) |-> fault_b_out && !gate_off_out
    && config_out == '0) else $error("outputs not at reset levels");
  AST_HOLD_NO_RISE: assert property ($rose(fault_b_out) && config_out.flag_hold_enable
    |-> since_cs < 6'd16) else $error("held fault released without a frame");
  cover property ($fell(fault_b_out));
  cover property ($rose(gate_off_out));
  cover property ($fell(cs_b_in) ##[1:1000] $rose(cs_b_in));
endmodule : pdsrb_register_bank_assertions

bind pdsrb_register_bank pdsrb_register_bank_assertions chk (.clk_in(clk_in),
  .rst_b_in(rst_b_in), .sck_in(sck_in), .cs_b_in(cs_b_in), .sdo_out(sdo_out),
  .sdo_oe_b_out(sdo_oe_b_out), .fault_live_in(fault_live_in),
  .thermal_live_in(thermal_live_in), .fault_b_out(fault_b_out),
  .gate_off_out(gate_off_out), .config_out(config_out));

// [tb/pdsrb_spi_master.sv]
`timescale 1ns/100ps
module pdsrb_spi_master (
  // Link pins
  output logic sck_out,
  output logic cs_b_out,
  output logic sdi_out,
  input wire logic sdo_in,
  // Frame result
  output logic [15:0] rx_out,
  output logic done_out
);
  initial begin
    sck_out = 1'b0;
    cs_b_out = 1'b1;
    sdi_out = 1'b0;
    rx_out = 16'h0000;
    done_out = 1'b0;
  end
  // Counts other than 16 only when the bench asks for a faulty frame
  task frame(input logic [15:0] w, input int n);
    #1.3;
    cs_b_out = 1'b0;
    #50;
    for (int i = 0; i < n; i++) begin
      sdi_out = (i < 16) ? w[15 - i] : 1'b0;
      #80;
      sck_out = 1'b1;
      if (i < 16) begin
        rx_out[15 - i] = sdo_in;
      end
      #80;
      sck_out = 1'b0;
    end
    #40;
    cs_b_out = 1'b1;
    sdi_out = 1'b0;
    done_out = (n == 16) && (w[15:14] == 2'h0);
    #10;
    done_out = 1'b0;
    #90;
  endtask : frame
endmodule : pdsrb_spi_master

// [tb/tb_pdsrb_register_bank.sv]
`timescale 1ns/100ps
module tb_pdsrb_register_bank;
  import pdsrb_pkg::*;
  logic clk_in;
  logic rst_b_in;
  wire logic sck, cs_b, sdi, sdo, sdo_oe_b, done, fault_b, gate_off;
  wire logic [15:0] rx;
  wire pdsrb_config_type cfg;
  pdsrb_faults_type fault_live_in;
  logic thermal_live_in;
  logic [2:0] cause;
  logic [15:0] exp_q[$];
  logic bad;
  logic [7:0] v;
  logic [7:0] m;
  logic [2:0] c;
  logic [2:0] k;
  int failures;
  int checks_done;
  int seed;
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  pdsrb_register_bank uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .sck_in(sck), .cs_b_in(cs_b),
    .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_b_out(sdo_oe_b), .fault_live_in(fault_live_in),
    .thermal_live_in(thermal_live_in), .undervolt_reset_cause_in(cause[2]),
    .watchdog_reset_cause_in(cause[1]), .clock_monitor_reset_cause_in(cause[0]),
    .fault_b_out(fault_b), .gate_off_out(gate_off), .config_out(cfg));
  pdsrb_spi_master mst (.sck_out(sck), .cs_b_out(cs_b), .sdi_out(sdi), .sdo_in(sdo),
    .rx_out(rx), .done_out(done));
  // ****
  // Tasks
  // ****
  task check(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      failures++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task wr(input logic [5:0] a, input logic [7:0] d);
    // Start just after a core edge so select never lands on one
    @(posedge clk_in);
    mst.frame({ACCESS_WRITE, a, d}, 16);
    bad = 1'b0;
  endtask : wr
  task rd(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_in);
    exp_q.push_back({1'b0, bad, 5'h00, 1'b1, d});
    mst.frame({ACCESS_READ, a, 8'h00}, 16);
    bad = 1'b0;
  endtask : rd
  task unlock(input logic [3:0] a, input logic [3:0] b, input logic [3:0] d);
    wr(ADDR_UNLOCK_KEY, {4'h0, a});
    wr(ADDR_UNLOCK_KEY, {4'h0, b});
    wr(ADDR_UNLOCK_KEY, {4'h0, d});
  endtask : unlock
  task drive(input logic [7:0] f, input logic t, input logic [2:0] r);
    @(posedge clk_in);
    fault_live_in <= f;
    thermal_live_in <= t;
    cause <= r;
    repeat (12) @(posedge clk_in);
  endtask : drive
  task outs(input logic fb, input logic go);
    @(negedge clk_in);
    check({14'h0000, fault_b, gate_off}, {14'h0000, fb, go});
  endtask : outs
  task summarize;
    if (failures == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  always @(posedge done) begin
    check(rx, exp_q.pop_front());
  end
  initial begin
    #500000;
    failures++;
    summarize();
  end
  // ****
  // Scenarios
  // ****
  initial begin
    seed = 33218;
    rst_b_in = 1'b0;
    fault_live_in = '0;
    thermal_live_in = 1'b0;
    cause = 3'h0;
    bad = 1'b0;
    failures = 0;
    checks_done = 0;
    repeat (20) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    for (int a = 0; a < 16; a++) begin
      if (a != 10) begin
        rd(a[5:0], (a == 4 || a == 6) ? 8'hff : (a == 5 || a == 7) ? 8'h01 : 8'h00);
      end
    end
    rd(6'h3f, 8'h00);
    wr(ADDR_FAULT_CONFIG, 8'h80);
    rd(ADDR_FAULT_CONFIG, 8'h00);
    unlock(KEY_FIRST, KEY_SECOND, 4'h3);
    wr(ADDR_UNLOCK_KEY, {4'h0, KEY_THIRD});
    wr(ADDR_FAULT_CONFIG, 8'h80);
    rd(ADDR_FAULT_CONFIG, 8'h00);
    unlock(KEY_FIRST, KEY_SECOND, KEY_THIRD);
    wr(ADDR_FAULT_CONFIG, 8'hff);
    rd(ADDR_FAULT_CONFIG, 8'hf7);
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      k = (c > MOTOR_TH_MAX) ? CODE_DEFAULT : c;
      wr(ADDR_FAULT_CONFIG, {1'b0, c, 1'b0, c[0], c[1:0]});
      wr(ADDR_CURRENT_SENSE_CONFIG, {5'h1f, c});
      wr(ADDR_GATE_DRIVE_CONFIG, {6'h3f, c[1:0]});
      wr(ADDR_SPARE_AND_HYSTERESIS, {6'h3f, c[1:0]});
      check({2'h0, cfg}, {3'h0, k, c[0], c[1:0], k, c[1:0], c[1:0]});
      rd(ADDR_SPARE_AND_HYSTERESIS, {6'h00, c[1:0]});
      rd(ADDR_GATE_DRIVE_CONFIG, {6'h00, c[1:0]});
    end
    wr(ADDR_FAULT_PIN_ENABLE_HIGH, 8'hfe);
    rd(ADDR_FAULT_PIN_ENABLE_HIGH, 8'h00);
    wr(ADDR_RESERVED_THREE, 8'hff);
    rd(ADDR_RESERVED_THREE, 8'h00);
    wr(ADDR_FAULT_PIN_ENABLE_HIGH, 8'h01);
    wr(ADDR_FAULT_CONFIG, 8'h80);
    check({15'h0000, cfg.flag_hold_enable}, 16'h0001);
    v = 8'($random(seed)) | 8'h01;
    m = 8'($random(seed));
    drive(v, 1'b1, 3'h0);
    drive(8'h00, 1'b0, 3'h0);
    outs(1'b0, 1'b1);
    rd(ADDR_FAULT_FLAGS_LOW, v);
    rd(ADDR_FAULT_FLAGS_HIGH, 8'h01);
    wr(ADDR_FAULT_FLAGS_LOW, m);
    rd(ADDR_FAULT_FLAGS_LOW, v & ~m);
    wr(ADDR_FAULT_FLAGS_LOW, 8'hff);
    wr(ADDR_FAULT_FLAGS_HIGH, 8'hff);
    rd(ADDR_FAULT_FLAGS_HIGH, 8'h00);
    outs(1'b1, 1'b0);
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_FAULT_CONFIG + 6'(i * (i > 0) + (i > 0)), 8'h00);
    end
    drive(v, 1'b1, 3'h0);
    outs(1'b1, 1'b0);
    wr(ADDR_FAULT_FLAGS_LOW, 8'hff);
    rd(ADDR_FAULT_FLAGS_LOW, v);
    wr(ADDR_FAULT_PIN_ENABLE_LOW, ~v);
    wr(ADDR_SHUTDOWN_ENABLE_LOW, ~v);
    outs(1'b1, 1'b0);
    wr(ADDR_FAULT_PIN_ENABLE_HIGH, 8'h01);
    outs(1'b0, 1'b0);
    wr(ADDR_SHUTDOWN_ENABLE_HIGH, 8'h01);
    outs(1'b0, 1'b1);
    drive(8'h00, 1'b0, 3'h0);
    wr(ADDR_UNLOCK_KEY, {4'h0, KEY_LOCK});
    wr(ADDR_GATE_DRIVE_CONFIG, 8'h00);
    rd(ADDR_GATE_DRIVE_CONFIG, 8'h03);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      mst.frame({(i > 1) ? 2'(i) : ACCESS_WRITE, ADDR_SPARE_AND_HYSTERESIS, 8'h00},
        (i == 0) ? 15 : (i == 1) ? 17 : 16);
      bad = 1'b1;
      rd(ADDR_SPARE_AND_HYSTERESIS, 8'h03);
    end
    rd(ADDR_SPARE_AND_HYSTERESIS, 8'h03);
    for (int i = 0; i < 3; i++) begin
      drive(8'h00, 1'b0, 3'(3'h1 << i));
      drive(8'h00, 1'b0, 3'h0);
      wr(ADDR_RESET_CAUSE, 8'h00);
      rd(ADDR_RESET_CAUSE, {5'h00, 3'(3'h1 << i)});
      rd(ADDR_RESET_CAUSE, 8'h00);
    end
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd(ADDR_FAULT_PIN_ENABLE_LOW, 8'hff);
    wr(ADDR_FAULT_PIN_ENABLE_LOW, 8'h00);
    rd(ADDR_FAULT_PIN_ENABLE_LOW, 8'hff);
    summarize();
  end
endmodule : tb_pdsrb_register_bank
